// ---- include/ofl_params.svh ----
// constants of the output frequency limiter: offsets, reset values, limits, timing
`ifndef OFL_PARAMS_SVH
`define OFL_PARAMS_SVH

// ****************************************************
// register byte offsets
// ****************************************************
`define OFL_OFS_UPPER    8'h00
`define OFL_OFS_LOWER    8'h04
`define OFL_OFS_HSUPPER  8'h08
`define OFL_OFS_JOG      8'h0c
`define OFL_OFS_STARTF   8'h10
`define OFL_OFS_GRPSEL   8'h14
`define OFL_OFS_JUMP0    8'h18
`define OFL_OFS_CTRL     8'h30
`define OFL_OFS_STEP     8'h34
`define OFL_OFS_MOTMAX   8'h38
`define OFL_OFS_REF      8'h3c
`define OFL_OFS_RUN      8'h40
`define OFL_OFS_STATUS   8'h44

// ****************************************************
// control bits
// ****************************************************
`define OFL_CTRL_START   0
`define OFL_CTRL_JOG     1
`define OFL_CTRL_VF      2
`define OFL_CTRL_PM      3

// ****************************************************
// frequencies, 0.1 Hz per lsb
// ****************************************************
`define OFL_F_ZERO       16'h0000
`define OFL_F_60HZ       16'h0258
`define OFL_F_120HZ      16'h04b0
`define OFL_F_400HZ      16'h0fa0
`define OFL_F_DISABLE    16'h270f
`define OFL_F_STEP_RST   16'h0001

// ****************************************************
// control update period
// ****************************************************
`define OFL_CLK_MHZ      40
`define OFL_UPD_NS       1000
`define OFL_UPD_CYC      ((`OFL_UPD_NS * `OFL_CLK_MHZ) / 1000)

`endif

// ---- include/ofl_pkg.sv ----
// types shared by the output frequency limiter modules
package ofl_pkg;

    typedef logic [15:0] ofl_freq_t;

    typedef enum logic [3:0] {
        RAMP_STOP = 4'b0001,
        RAMP_ACC  = 4'b0010,
        RAMP_DEC  = 4'b0100,
        RAMP_HOLD = 4'b1000
    } ofl_ramp_e;

endpackage

// ---- src/ofl_jump_band.sv ----
// one frequency jump band: detects a command inside the band
`timescale 1ns/100ps
`include "ofl_params.svh"

module ofl_jump_band
    import ofl_pkg::*;
(
    // band settings
    input  wire ofl_freq_t first,
    input  wire ofl_freq_t second,
    // command
    input  wire ofl_freq_t cmd,
    output logic           hit
);

    logic      active;
    ofl_freq_t lo;
    ofl_freq_t hi;

    // either edge may be the first-of-pair value
    always_comb begin
        active = (first != `OFL_F_DISABLE) && (second != `OFL_F_DISABLE);
        lo     = (first < second) ? first : second;
        hi     = (first < second) ? second : first;
        hit    = active && (cmd >= lo) && (cmd <= hi);
    end

endmodule

// ---- src/ofl_ramp.sv ----
// running frequency ramp toward the limited reference
`timescale 1ns/100ps
`include "ofl_params.svh"

module ofl_ramp
    import ofl_pkg::*;
(
    // clock and reset
    input  wire logic      hclk,
    input  wire logic      hresetn,
    // control
    input  wire logic      tick,
    input  wire ofl_freq_t target,
    input  wire ofl_freq_t step,
    input  wire logic      stall,
    // state
    output ofl_freq_t      run_ff,
    output ofl_ramp_e      state_ff
);

    ofl_freq_t diff_up;
    ofl_freq_t diff_dn;

    always_comb begin
        diff_up = (target > run_ff) ? (target - run_ff) : `OFL_F_ZERO;
        diff_dn = (run_ff > target) ? (run_ff - target) : run_ff;
        if (diff_up > step) begin
            diff_up = step;
        end
        if (diff_dn > step) begin
            diff_dn = step;
        end
    end

    // ramp moves through jump bands; only the target is substituted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_ff   <= `OFL_F_ZERO;
            state_ff <= RAMP_STOP;
        end else if (tick) begin
            case (1'b1)
                stall: begin
                    // stall relief ignores the lower clamp
                    run_ff   <= run_ff - diff_dn;
                    state_ff <= RAMP_DEC;
                end
                (run_ff < target): begin
                    run_ff   <= run_ff + diff_up;
                    state_ff <= RAMP_ACC;
                end
                (run_ff > target): begin
                    run_ff   <= run_ff - diff_dn;
                    state_ff <= RAMP_DEC;
                end
                default: begin
                    state_ff <= (run_ff == `OFL_F_ZERO) ? RAMP_STOP : RAMP_HOLD;
                end
            endcase
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_stall_drop;
        tick && stall && (run_ff != `OFL_F_ZERO) |=> run_ff < $past(run_ff);
    endproperty
    a_stall_drop: assert property (p_stall_drop) else $error("stall did not lower run");

    property p_accel;
        tick && !stall && (run_ff < target) && (step != `OFL_F_ZERO) |=> run_ff > $past(run_ff);
    endproperty
    a_accel: assert property (p_accel) else $error("ramp did not accelerate");

endmodule

// ---- src/ofl_limiter.sv ----
// output frequency limiter with ahb-lite register slave
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`include "ofl_params.svh"


module ofl_limiter
    import ofl_pkg::*;
#(
    parameter bit          SMALL_UNIT = 1'b1,
    parameter int unsigned UPD_CYC    = `OFL_UPD_CYC,
    parameter int unsigned N_BANDS    = 3
)(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // command sources
    input  wire ofl_freq_t   freq_cmd,
    input  wire ofl_freq_t   est_freq,
    input  wire logic        stall_req,
    // limited output
    output ofl_freq_t        freq_ref,
    output ofl_freq_t        run_freq,
    output logic             update_tick
);

    localparam ofl_freq_t UPPER_RST = SMALL_UNIT ? `OFL_F_120HZ : `OFL_F_60HZ;
    localparam int unsigned CW = (UPD_CYC > 1) ? $clog2(UPD_CYC) : 1;

    // ****************************************************
    // registers
    // ****************************************************
    ofl_freq_t   upper_ff;
    ofl_freq_t   lower_ff;
    ofl_freq_t   hs_ff;
    ofl_freq_t   jog_ff;
    ofl_freq_t   startf_ff;
    ofl_freq_t   grpsel_ff;
    ofl_freq_t   step_ff;
    ofl_freq_t   motmax_ff;
    logic [3:0]  ctrl_ff;
    ofl_freq_t   jump_ff [2*N_BANDS];
    ofl_freq_t   ref_ff;
    logic [31:0] rdata_ff;
    logic        wr_pend_ff;
    logic [7:0]  wr_addr_ff;
    logic [CW-1:0] div_ff;
    logic        tick_ff;
    ofl_freq_t   run_w;
    ofl_ramp_e   ramp_st_w;

    // ****************************************************
    // bus decode
    // ****************************************************
    function automatic logic hit_at(input logic [7:0] a, input logic [7:0] ofs);
        hit_at = (a == ofs);
    endfunction

    function automatic logic in_jump_range(input logic [7:0] a);
        in_jump_range = (a >= `OFL_OFS_JUMP0) && (a < (`OFL_OFS_JUMP0 + 8'(4 * 2 * N_BANDS)))
                        && (a[1:0] == 2'b00);
    endfunction

    logic      addr_ok;
    ofl_freq_t wd;
    logic      grp_open;
    logic      wr_upper;
    logic      wr_lower;
    logic      wr_hs;

    assign addr_ok  = hsel && hready && htrans[1];
    assign wd       = hwdata[15:0];
    assign grp_open = (grpsel_ff == `OFL_F_ZERO);
    // out-of-range values are dropped
    assign wr_upper = wr_pend_ff && hit_at(wr_addr_ff, `OFL_OFS_UPPER) && (wd <= `OFL_F_120HZ);
    assign wr_lower = wr_pend_ff && hit_at(wr_addr_ff, `OFL_OFS_LOWER) && (wd <= `OFL_F_120HZ);
    assign wr_hs    = wr_pend_ff && hit_at(wr_addr_ff, `OFL_OFS_HSUPPER) && grp_open
                      && (wd >= `OFL_F_120HZ) && (wd <= `OFL_F_400HZ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_ok && hwrite && (hsize == 3'h2);
            wr_addr_ff <= haddr[7:0];
        end
    end

    // zero-wait slave, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ****************************************************
    // limit settings
    // ****************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upper_ff <= UPPER_RST;
            hs_ff    <= UPPER_RST;
            lower_ff <= `OFL_F_ZERO;
        end else begin
            if (wr_upper) begin
                upper_ff <= wd;
                hs_ff    <= wd;
            end else if (wr_hs) begin
                hs_ff    <= wd;
                upper_ff <= wd;
            end
            if (wr_lower) begin
                lower_ff <= wd;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            jog_ff    <= `OFL_F_ZERO;
            startf_ff <= `OFL_F_ZERO;
            grpsel_ff <= `OFL_F_ZERO;
            step_ff   <= `OFL_F_STEP_RST;
            motmax_ff <= `OFL_F_400HZ;
            ctrl_ff   <= 4'h0;
        end else if (wr_pend_ff) begin
            case (wr_addr_ff)
                `OFL_OFS_JOG:    jog_ff    <= wd;
                `OFL_OFS_STARTF: startf_ff <= wd;
                `OFL_OFS_GRPSEL: grpsel_ff <= wd;
                `OFL_OFS_STEP:   step_ff   <= wd;
                `OFL_OFS_MOTMAX: motmax_ff <= wd;
                `OFL_OFS_CTRL:   ctrl_ff   <= hwdata[3:0];
                default:         ctrl_ff   <= ctrl_ff;
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2 * N_BANDS; gi++) begin : g_jump_reg
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    jump_ff[gi] <= `OFL_F_DISABLE;
                end else if (wr_pend_ff && grp_open && in_jump_range(wr_addr_ff)
                             && (wr_addr_ff[7:2] == 6'((`OFL_OFS_JUMP0 >> 2) + gi))
                             && ((wd <= `OFL_F_400HZ) || (wd == `OFL_F_DISABLE))) begin
                    jump_ff[gi] <= wd;
                end
            end
        end
    endgenerate

    // ****************************************************
    // read data, taken in the address phase
    // ****************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            rdata_ff <= 32'h0000_0000;
            case (haddr[7:0])
                `OFL_OFS_UPPER:   rdata_ff[15:0] <= upper_ff;
                `OFL_OFS_LOWER:   rdata_ff[15:0] <= lower_ff;
                `OFL_OFS_HSUPPER: rdata_ff[15:0] <= hs_ff;
                `OFL_OFS_JOG:     rdata_ff[15:0] <= jog_ff;
                `OFL_OFS_STARTF:  rdata_ff[15:0] <= startf_ff;
                `OFL_OFS_GRPSEL:  rdata_ff[15:0] <= grpsel_ff;
                `OFL_OFS_CTRL:    rdata_ff[3:0]  <= ctrl_ff;
                `OFL_OFS_STEP:    rdata_ff[15:0] <= step_ff;
                `OFL_OFS_MOTMAX:  rdata_ff[15:0] <= motmax_ff;
                `OFL_OFS_REF:     rdata_ff[15:0] <= ref_ff;
                `OFL_OFS_RUN:     rdata_ff[15:0] <= run_w;
                `OFL_OFS_STATUS:  rdata_ff[3:0]  <= ramp_st_w;
                default: begin
                    if (in_jump_range(haddr[7:0])) begin
                        rdata_ff[15:0] <= jump_ff[3'(haddr[7:2] - (`OFL_OFS_JUMP0 >> 2))];
                    end
                end
            endcase
        end
    end

    assign hrdata = rdata_ff;

    // ****************************************************
    // control update divider
    // ****************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (div_ff == CW'(UPD_CYC - 1));
            div_ff  <= (div_ff == CW'(UPD_CYC - 1)) ? '0 : div_ff + 1'b1;
        end
    end

    assign update_tick = tick_ff;

    // ****************************************************
    // jump substitution and clamps
    // ****************************************************
    logic [N_BANDS-1:0] band_hit;
    ofl_freq_t jumped;
    ofl_freq_t hs_eff;
    ofl_freq_t upper_eff;
    ofl_freq_t cmp;
    ofl_freq_t tgt;
    logic      jog_on;
    logic      pm_on;
    logic      jog_low;

    generate
        for (gi = 0; gi < N_BANDS; gi++) begin : g_band
            ofl_jump_band u_band (
                .first  (jump_ff[2*gi]),
                .second (jump_ff[2*gi+1]),
                .cmd    (freq_cmd),
                .hit    (band_hit[gi])
            );
        end
    endgenerate

    assign jog_on  = ctrl_ff[`OFL_CTRL_JOG];
    assign pm_on   = ctrl_ff[`OFL_CTRL_PM];
    assign jog_low = jog_on && (jog_ff <= lower_ff);

    always_comb begin
        // lowest numbered band wins when bands overlap
        jumped = freq_cmd;
        for (int b = N_BANDS - 1; b >= 0; b--) begin
            if (band_hit[b]) begin
                jumped = jump_ff[2*b];
            end
        end
        if (jog_on) begin
            jumped = jog_ff;
        end
        hs_eff = (pm_on && (hs_ff > motmax_ff)) ? motmax_ff : hs_ff;
        upper_eff = (upper_ff > `OFL_F_120HZ) ? `OFL_F_120HZ : upper_ff;
        if ((ctrl_ff[`OFL_CTRL_VF] || pm_on) && (hs_eff > `OFL_F_120HZ)) begin
            upper_eff = hs_eff;
        end else if (pm_on && (upper_eff > hs_eff)) begin
            upper_eff = hs_eff;
        end
        // pm control judges the estimate, so the monitored value may overshoot
        cmp = pm_on ? est_freq : jumped;
        tgt = jumped;
        if (cmp > upper_eff) begin
            tgt = (jumped > (cmp - upper_eff)) ? (jumped - (cmp - upper_eff)) : `OFL_F_ZERO;
        end else if ((cmp < lower_ff) && !jog_low) begin
            tgt = jumped + (lower_ff - cmp);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_ff <= `OFL_F_ZERO;
        end else if (tick_ff) begin
            ref_ff <= tgt;
        end
    end

    assign freq_ref = ref_ff;

    // ****************************************************
    // ramp
    // ****************************************************
    ofl_freq_t run_tgt;

    // below the starting frequency the drive stays at rest
    assign run_tgt = (ctrl_ff[`OFL_CTRL_START] && (ref_ff >= startf_ff)) ? ref_ff : `OFL_F_ZERO;

    ofl_ramp u_ramp (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .tick     (tick_ff),
        .target   (run_tgt),
        .step     (step_ff),
        .stall    (stall_req),
        .run_ff   (run_w),
        .state_ff (ramp_st_w)
    );

    assign run_freq = run_w;

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_plain_tick;
        tick_ff && !pm_on && !jog_on;
    endsequence

    property p_upper_clamp;
        s_plain_tick ##0 (jumped > upper_eff) |=> (ref_ff == $past(upper_eff));
    endproperty
    a_upper_clamp: assert property (p_upper_clamp) else $error("upper clamp missed");

    property p_lower_clamp;
        s_plain_tick ##0 (jumped < lower_ff) && (upper_eff >= lower_ff) |=> (ref_ff == $past(lower_ff));
    endproperty
    a_lower_clamp: assert property (p_lower_clamp) else $error("lower clamp missed");

    property p_copy_upper;
        wr_upper |=> (hs_ff == upper_ff) && (upper_ff == $past(wd));
    endproperty
    a_copy_upper: assert property (p_copy_upper) else $error("upper not copied");

    property p_hs_locked;
        wr_pend_ff && hit_at(wr_addr_ff, `OFL_OFS_HSUPPER) && !grp_open |=> $stable(hs_ff);
    endproperty
    a_hs_locked: assert property (p_hs_locked) else $error("locked write taken");

    property p_jog_low;
        tick_ff && jog_low && !pm_on && (jog_ff <= upper_eff) |=> (ref_ff == $past(jog_ff));
    endproperty
    a_jog_low: assert property (p_jog_low) else $error("jog not honoured");

    property p_band1;
        s_plain_tick ##0 band_hit[0] && (jump_ff[0] <= upper_eff) && (jump_ff[0] >= lower_ff)
            |=> (ref_ff == $past(jump_ff[0]));
    endproperty
    a_band1: assert property (p_band1) else $error("jump band not applied");

    property p_hs_mode;
        ctrl_ff[`OFL_CTRL_VF] && !pm_on && (hs_ff > `OFL_F_120HZ) |-> (upper_eff == hs_ff);
    endproperty
    a_hs_mode: assert property (p_hs_mode) else $error("high-speed limit ignored");

    property p_pm_cap;
        pm_on && (upper_eff > `OFL_F_120HZ) |-> (upper_eff <= motmax_ff);
    endproperty
    a_pm_cap: assert property (p_pm_cap) else $error("motor maximum exceeded");

    property p_range;
        wr_pend_ff && hit_at(wr_addr_ff, `OFL_OFS_LOWER) && (wd > `OFL_F_120HZ) |=> $stable(lower_ff);
    endproperty
    a_range: assert property (p_range) else $error("out-of-range lower taken");

endmodule

// ---- testbench/ofl_cmd_src.sv ----
// command source model standing in front of the frequency limiter
`timescale 1ns/100ps
`include "ofl_params.svh"

module ofl_cmd_src
    import ofl_pkg::*;
(
    // clock and reset
    input  wire logic      hclk,
    input  wire logic      hresetn,
    // requests from the bench
    input  wire ofl_freq_t cmd_in,
    input  wire ofl_freq_t est_in,
    input  wire logic      stall_in,
    input  wire ofl_freq_t gain_freq,
    // toward the limiter
    output ofl_freq_t      freq_cmd,
    output ofl_freq_t      est_freq,
    output logic           stall_req
);
    // an analog command saturates at the gain setting; raising the limits alone never lifts it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_cmd  <= `OFL_F_ZERO;
            est_freq  <= `OFL_F_ZERO;
            stall_req <= 1'b0;
        end else begin
            freq_cmd  <= (cmd_in > gain_freq) ? gain_freq : cmd_in;
            est_freq  <= est_in;
            stall_req <= stall_in;
        end
    end
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the output frequency limiter
`timescale 1ns/100ps
`include "ofl_params.svh"

module tb;
    import ofl_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    ofl_freq_t   freq_cmd;
    ofl_freq_t   est_freq;
    logic        stall_req;
    ofl_freq_t   freq_ref;
    ofl_freq_t   run_freq;
    logic        update_tick;
    ofl_freq_t   cmd_in = 16'h0;
    ofl_freq_t   est_in = 16'h0;
    logic        stall_in = 1'b0;
    ofl_freq_t   gain_freq = 16'h0fa0;
    logic        saw_mid = 1'b0;
    int          bad_count = 0;
    int          total_checks = 0;

    always #12.5 hclk = ~hclk;

    ofl_cmd_src src (.hclk(hclk), .hresetn(hresetn), .cmd_in(cmd_in), .est_in(est_in), .stall_in(stall_in),
        .gain_freq(gain_freq), .freq_cmd(freq_cmd), .est_freq(est_freq), .stall_req(stall_req));
    // short update period keeps ramp runs brief
    ofl_limiter #(.UPD_CYC(4)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .freq_cmd(freq_cmd), .est_freq(est_freq),
        .stall_req(stall_req), .freq_ref(freq_ref), .run_freq(run_freq), .update_tick(update_tick));

    always @(posedge hclk) begin
        if (run_freq === 16'h0096) begin
            saw_mid <= 1'b1;
        end
    end

    // ****************************************************
    // shared tasks
    // ****************************************************
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one single word transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] ofs, input ofl_freq_t val);
        logic [31:0] d;
        bus(1'b1, ofs, {16'h0, val}, d);
    endtask

    task automatic rdc(input logic [7:0] ofs, input ofl_freq_t exp, input string what);
        logic [31:0] d;
        bus(1'b0, ofs, 32'h0, d);
        chk(what, d, {16'h0, exp});
    endtask

    // lets three control updates pass so the reference has settled
    task automatic settle;
        repeat (3) begin
            @(negedge hclk);
            while (update_tick !== 1'b1) @(negedge hclk);
        end
        @(negedge hclk);
    endtask

    task automatic ref_is(input ofl_freq_t cmd, input ofl_freq_t exp);
        @(posedge hclk);
        cmd_in <= cmd;
        settle();
        chk("freq_ref", {16'h0, freq_ref}, {16'h0, exp});
    endtask

    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_reset;
        rdc(`OFL_OFS_UPPER, 16'h04b0, "upper");
        rdc(`OFL_OFS_HSUPPER, 16'h04b0, "hs upper");
        rdc(`OFL_OFS_LOWER, 16'h0000, "lower");
        for (int i = 0; i < 6; i++) begin
            rdc(`OFL_OFS_JUMP0 + 8'(4 * i), 16'h270f, "jump");
        end
        wr(8'h48, 16'h1234);
        rdc(8'h48, 16'h0000, "unmapped");
    endtask

    task automatic t_limits;
        wr(`OFL_OFS_UPPER, 16'h01f4);
        rdc(`OFL_OFS_HSUPPER, 16'h01f4, "hs copy");
        wr(`OFL_OFS_UPPER, 16'h04b1);
        rdc(`OFL_OFS_UPPER, 16'h01f4, "upper range");
        ref_is(16'h0320, 16'h01f4);
        rdc(`OFL_OFS_REF, 16'h01f4, "ref reg");
        wr(`OFL_OFS_LOWER, 16'h00c8);
        ref_is(16'h0064, 16'h00c8);
        wr(`OFL_OFS_JOG, 16'h0096);
        wr(`OFL_OFS_CTRL, 16'h0002);
        ref_is(16'h0064, 16'h0096);
        wr(`OFL_OFS_CTRL, 16'h0000);
    endtask

    task automatic t_high;
        wr(`OFL_OFS_HSUPPER, 16'h0bb8);
        rdc(`OFL_OFS_UPPER, 16'h0bb8, "upper copy");
        ref_is(16'h09c4, 16'h04b0);
        wr(`OFL_OFS_CTRL, 16'h0004);
        ref_is(16'h09c4, 16'h09c4);
        // an analog source capped at 60 Hz stays there whatever the limits
        @(posedge hclk);
        gain_freq <= 16'h0258;
        ref_is(16'h09c4, 16'h0258);
        @(posedge hclk);
        gain_freq <= 16'h0fa0;
        wr(`OFL_OFS_HSUPPER, 16'h0fa1);
        rdc(`OFL_OFS_HSUPPER, 16'h0bb8, "hs range");
        wr(`OFL_OFS_GRPSEL, 16'h0001);
        wr(`OFL_OFS_HSUPPER, 16'h07d0);
        rdc(`OFL_OFS_HSUPPER, 16'h0bb8, "hs locked");
        wr(`OFL_OFS_JUMP0, 16'h0064);
        rdc(`OFL_OFS_JUMP0, 16'h270f, "jump locked");
        wr(`OFL_OFS_GRPSEL, 16'h0000);
        wr(`OFL_OFS_MOTMAX, 16'h05dc);
        wr(`OFL_OFS_CTRL, 16'h0008);
        est_in <= 16'h07d0;
        ref_is(16'h07d0, 16'h05dc);
        ref_is(16'h0708, 16'h0514);
        @(posedge hclk);
        est_in <= 16'h0000;
        wr(`OFL_OFS_CTRL, 16'h0000);
    endtask

    task automatic t_jump;
        wr(`OFL_OFS_UPPER, 16'h04b0);
        wr(`OFL_OFS_JUMP0, 16'h015e);
        wr(`OFL_OFS_JUMP0 + 8'h04, 16'h012c);
        ref_is(16'h0140, 16'h015e);
        wr(`OFL_OFS_JUMP0 + 8'h08, 16'h01f4);
        wr(`OFL_OFS_JUMP0 + 8'h0c, 16'h0226);
        ref_is(16'h021c, 16'h01f4);
        wr(`OFL_OFS_JUMP0 + 8'h10, 16'h0032);
        wr(`OFL_OFS_JUMP0 + 8'h14, 16'h0050);
        ref_is(16'h003c, 16'h00c8);
        wr(`OFL_OFS_JUMP0 + 8'h04, 16'h270f);
        ref_is(16'h0140, 16'h0140);
    endtask

    // start with no command runs up to the lower limit, passing a band
    task automatic t_ramp;
        wr(`OFL_OFS_JUMP0 + 8'h10, 16'h0096);
        wr(`OFL_OFS_JUMP0 + 8'h14, 16'h0064);
        wr(`OFL_OFS_STEP, 16'h0032);
        wr(`OFL_OFS_STARTF, 16'h0064);
        ref_is(16'h0000, 16'h00c8);
        wr(`OFL_OFS_CTRL, 16'h0001);
        settle();
        settle();
        chk("run_freq", {16'h0, run_freq}, 32'h0000_00c8);
        rdc(`OFL_OFS_RUN, 16'h00c8, "run reg");
        rdc(`OFL_OFS_STATUS, 16'h0008, "ramp hold");
        chk("through band", {31'h0, saw_mid}, 32'h1);
        @(posedge hclk);
        stall_in <= 1'b1;
        settle();
        settle();
        chk("stall relief", {31'h0, run_freq <= 16'h0032}, 32'h1);
        @(posedge hclk);
        stall_in <= 1'b0;
    endtask

    // ****************************************************
    // main sequence and watchdog
    // ****************************************************
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("hresp", {31'h0, hresp}, 32'h0);
        t_reset();
        t_limits();
        t_high();
        t_jump();
        t_ramp();
        close_out();
    end

    initial begin
        #(25 * 20000);
        bad_count++;
        close_out();
    end
endmodule
